// ---- rtl/vim_top.sv ----
// Vectored interrupt mapper: line mapping, pending state, nesting and core request.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Thirty-two individually vectored interrupt lines.
// - Four levels, mask at execution priority.
// - Save state on entry, restore on return.
// - Equal levels: lowest line served first.
// - Line asserted when any combined condition.
// - Lines 0-10 wake from port pins.
// - Line 11 radio, 12 clock wake.
// - Line 13 radio access, command, acknowledge.
// - Line 14 clock timer event.
// - Line 17 field power detected.
// - Line 19 brownout supply drop.
// - Line 20 serial port queue events.
// - Line 21 temperature sensor events.
// - Line 24 current converter events.
// - Line 31 port combined status.
module vim_top (
  input  wire logic                          CLK,
  input  wire logic                          RESET_N,
  input  wire logic [vim_pkg::PIN_COUNT-1:0] PORT0_PINS,
  input  var  vim_pkg::vim_source_type       SOURCES,
  input  wire logic [vim_pkg::NUM_LINES-1:0] IRQ_ENABLE,
  input  var  vim_pkg::vim_prio_array_type   IRQ_PRIORITY,
  input  wire logic [vim_pkg::NUM_LINES-1:0] SW_SET_PEND,
  input  wire logic [vim_pkg::NUM_LINES-1:0] SW_CLEAR_PEND,
  input  wire logic                          CORE_TAKE,
  input  wire logic                          CORE_RETURN,
  input  wire logic [vim_pkg::STATE_W-1:0]   CORE_STATE,
  output var  vim_pkg::vim_request_type      IRQ_REQ,
  output logic [vim_pkg::EXEC_W-1:0]         EXEC_PRIO,
  output logic [vim_pkg::NUM_LINES-1:0]      PENDING,
  output logic [vim_pkg::NUM_LINES-1:0]      ACTIVE,
  output logic [vim_pkg::STATE_W-1:0]        RESTORED_STATE,
  output logic                               RESTORE_VALID
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [1:0]                          rst_sync;     // Reset release chain.
  logic                                rst_n;        // Released reset used everywhere.
  logic [vim_pkg::PIN_COUNT-1:0]       pin_s1;       // First pin stage, read only by pin_s2.
  logic [vim_pkg::PIN_COUNT-1:0]       pin_s2;       // Second pin stage.
  logic [vim_pkg::PIN_COUNT-1:0]       pin_s3;       // Third pin stage.
  logic [vim_pkg::PIN_COUNT-1:0]       pin_stable;   // Accepted pin levels.
  logic [vim_pkg::PIN_COUNT-1:0]       next_pin_stable;
  logic [vim_pkg::NUM_LINES-1:0]       line_level;   // Mapped source level per line.
  logic [vim_pkg::NUM_LINES-1:0]       next_pending;
  logic [vim_pkg::NUM_LINES-1:0]       next_active;
  logic [vim_pkg::EXEC_W-1:0]          next_exec;
  logic [vim_pkg::DEPTH_W-1:0]         depth;        // Number of nested handlers.
  logic [vim_pkg::DEPTH_W-1:0]         next_depth;
  logic [vim_pkg::STATE_W-1:0]         saved_state [vim_pkg::NEST_DEPTH]; // Frame store.
  logic [vim_pkg::EXEC_W-1:0]          saved_exec  [vim_pkg::NEST_DEPTH];
  logic [vim_pkg::LINE_W-1:0]          saved_line  [vim_pkg::NEST_DEPTH];
  logic [vim_pkg::STATE_W-1:0]         top_state;    // State at the stack top.
  logic [vim_pkg::EXEC_W-1:0]          top_exec;
  logic [vim_pkg::LINE_W-1:0]          top_line;
  logic [1:0]                          top_idx;      // Frame slot of the newest handler.
  logic                                lower_tie;    // A passed-over line exists; checker only.
  logic                                do_take;      // Core accepts the shown request.
  logic                                do_return;    // Core leaves a handler.
  logic [vim_pkg::NUM_LINES-1:0]       next_cand;    // Candidates after this edge.
  vim_pkg::vim_request_type            next_req;
  logic [vim_pkg::STATE_W-1:0]         next_restored;
  logic                                next_restore_valid;

  // Decode a line number into a one-hot line mask.
  function automatic logic [vim_pkg::NUM_LINES-1:0] line_mask(
    input logic [vim_pkg::LINE_W-1:0] line
  );
    line_mask = '0;
    line_mask[line] = 1'b1;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Reset release: asynchronous assertion, two-flop synchronous release.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  //////////////////////////////////////////////////////////////////////////////
  // Pin wake inputs come from outside the clock domain; a level is accepted
  // only once the second and third stages agree, filtering one-cycle glitches.
  always_comb begin
    next_pin_stable = pin_stable;
    for (int i = 0; i < vim_pkg::PIN_COUNT; i++) begin
      if (pin_s2[i] == pin_s3[i]) begin
        next_pin_stable[i] = pin_s3[i];
      end
    end
  end

  // Pin synchroniser registers.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1     <= '0;
      pin_s2     <= '0;
      pin_s3     <= '0;
      pin_stable <= '0;
    end else begin
      pin_s1     <= PORT0_PINS;
      pin_s2     <= pin_s1;
      pin_s3     <= pin_s2;
      pin_stable <= next_pin_stable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Source to line mapping; each line other than the radio wake line 11 is the OR of its peripheral's flags.
  // Any combined flag raises its line.
  always_comb begin
    line_level = '0;
    line_level[vim_pkg::PIN_COUNT-1:0] = pin_stable;
    line_level[vim_pkg::LINE_RADIO_WAKE] = SOURCES.radio_access;
    line_level[vim_pkg::LINE_RTC_WAKE]   = SOURCES.rtc_event;
    line_level[vim_pkg::LINE_RADIO] = SOURCES.radio_access | SOURCES.radio_command
                                    | SOURCES.radio_read_ack;
    line_level[vim_pkg::LINE_RTC] = SOURCES.rtc_event;
    line_level[vim_pkg::LINE_TWI]     = SOURCES.twi_state_change;
    line_level[vim_pkg::LINE_TIMER16] = |SOURCES.timer16_match;
    line_level[vim_pkg::LINE_TIMER32] = |SOURCES.timer32_match;
    line_level[vim_pkg::LINE_FIELD_PWR] = SOURCES.field_power;
    line_level[vim_pkg::LINE_BROWNOUT] = SOURCES.brownout;
    line_level[vim_pkg::LINE_SPI] = SOURCES.spi_tx_half_empty | SOURCES.spi_rx_half_full
                                  | SOURCES.spi_rx_timeout | SOURCES.spi_rx_overrun;
    line_level[vim_pkg::LINE_TEMPERATURE_SENSOR] = SOURCES.temperature_sensor_done | SOURCES.temperature_sensor_low
                                    | SOURCES.temperature_sensor_high;
    line_level[vim_pkg::LINE_I2D] = SOURCES.i2d_done | SOURCES.i2d_low | SOURCES.i2d_high;
    line_level[vim_pkg::LINE_CONVERTER] = SOURCES.converter_irq;
    line_level[vim_pkg::LINE_WATCHDOG]  = SOURCES.watchdog_irq;
    line_level[vim_pkg::LINE_FLASH]     = SOURCES.flash_irq;
    line_level[vim_pkg::LINE_NVMEM]     = SOURCES.nvmem_irq;
    line_level[vim_pkg::LINE_PORT0] = SOURCES.port0_status;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pending, active, nesting and request next-state logic.
  assign do_take   = IRQ_REQ.valid && CORE_TAKE && (depth < vim_pkg::DEPTH_FULL);
  assign do_return = CORE_RETURN && (depth != vim_pkg::DEPTH_NONE);
  // The slot index wraps when no handler runs; it is only used on a return,
  // which needs a handler, so the wrapped slot is never applied.
  assign top_idx   = 2'(depth - vim_pkg::DEPTH_ONE);
  assign top_state = saved_state[top_idx];
  assign top_exec  = saved_exec[top_idx];
  assign top_line  = saved_line[top_idx];

  always_comb begin
    logic [vim_pkg::NUM_LINES-1:0] set_mask;
    logic [vim_pkg::NUM_LINES-1:0] clr_mask;
    set_mask = (line_level & ~ACTIVE) | SW_SET_PEND;
    clr_mask = SW_CLEAR_PEND | (do_take ? line_mask(IRQ_REQ.line) : '0);
    // A set in the same cycle as a clear wins, so no event is lost.
    next_pending = (PENDING & ~clr_mask) | set_mask;
    next_active  = ACTIVE;
    next_exec    = EXEC_PRIO;
    next_depth   = depth;
    next_restored      = RESTORED_STATE;
    next_restore_valid = 1'b0;
    // A return wins over a take in the same cycle, so the core sees the restored level; that take only clears its pending bit.
    if (do_return) begin
      next_active        = next_active & ~line_mask(top_line);
      next_exec          = top_exec;
      next_depth         = depth - vim_pkg::DEPTH_ONE;
      next_restored      = top_state;
      next_restore_valid = 1'b1;
    end else if (do_take) begin
      next_active = next_active | line_mask(IRQ_REQ.line);
      next_exec   = {1'b0, IRQ_REQ.prio};
      next_depth  = depth + vim_pkg::DEPTH_ONE;
    end
    next_cand = next_pending & IRQ_ENABLE & ~next_active;
  end

  // The arbiter sees next-state values so the registered request never
  // shows a line that the core has just taken.
  vim_arbiter u_arbiter (
    .cand      (next_cand),
    .prio      (IRQ_PRIORITY),
    .exec_prio (next_exec),
    .pick      (next_req)
  );

  // State registers; the frame store is written only on a take.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PENDING        <= '0;
      ACTIVE         <= '0;
      EXEC_PRIO      <= vim_pkg::EXEC_IDLE;
      depth          <= vim_pkg::DEPTH_NONE;
      IRQ_REQ        <= '0;
      RESTORED_STATE <= '0;
      RESTORE_VALID  <= 1'b0;
      for (int i = 0; i < vim_pkg::NEST_DEPTH; i++) begin
        saved_state[i] <= '0;
        saved_exec[i]  <= vim_pkg::EXEC_IDLE;
        saved_line[i]  <= '0;
      end
    end else begin
      PENDING        <= next_pending;
      ACTIVE         <= next_active;
      EXEC_PRIO      <= next_exec;
      depth          <= next_depth;
      IRQ_REQ        <= next_req;
      RESTORED_STATE <= next_restored;
      RESTORE_VALID  <= next_restore_valid;
      if (do_take && !do_return) begin
        saved_state[depth[1:0]] <= CORE_STATE;
        saved_exec[depth[1:0]]  <= EXEC_PRIO;
        saved_line[depth[1:0]]  <= IRQ_REQ.line;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking @(posedge CLK); endclocking
  default disable iff (!rst_n);

  // Tie helper: a candidate below the winner's line at an equal or more urgent
  // level means the arbiter passed over a line that should have won.
  always_comb begin
    lower_tie = 1'b0;
    for (int i = 0; i < vim_pkg::NUM_LINES; i++) begin
      if (next_cand[i] && (IRQ_PRIORITY[i] <= next_req.prio)
          && (vim_pkg::LINE_W'(i) < next_req.line)) begin
        lower_tie = 1'b1;
      end
    end
  end

  a_req_masked: assert property (
    IRQ_REQ.valid |-> ({1'b0, IRQ_REQ.prio} < EXEC_PRIO))
    else $error("Request shown at or below execution priority.");
  a_req_pending: assert property (
    IRQ_REQ.valid |-> PENDING[IRQ_REQ.line] && !ACTIVE[IRQ_REQ.line])
    else $error("Request for a line not pending or already active.");
  // A source still high or a software set at the take re-pends the line, as set wins.
  a_take_entry: assert property (
    do_take && !do_return && !line_level[IRQ_REQ.line] && !SW_SET_PEND[IRQ_REQ.line]
    |=> ACTIVE[$past(IRQ_REQ.line)] && !PENDING[$past(IRQ_REQ.line)]
        && EXEC_PRIO == {1'b0, $past(IRQ_REQ.prio)})
    else $error("Taken line not active at its level.");
  a_state_restore: assert property (
    do_return |=> RESTORE_VALID && RESTORED_STATE == $past(top_state)
                  && EXEC_PRIO == $past(top_exec))
    else $error("Saved state not restored on return.");
  a_tie_lowest: assert property (
    next_req.valid |-> !lower_tie)
    else $error("Equal level tie not given to lowest line.");
  a_spi_combine: assert property (
    SOURCES.spi_rx_timeout && !ACTIVE[vim_pkg::LINE_SPI] |=> PENDING[vim_pkg::LINE_SPI])
    else $error("Serial port condition did not pend its line.");
  a_pin_wake: assert property (
    pin_s2[0] && pin_s3[0] ##1 !ACTIVE[0] |=> PENDING[0])
    else $error("Stable pin level did not pend wake line.");
  a_tied_lines: assert property (
    {line_level[vim_pkg::LINE_SPARE_A], line_level[vim_pkg::LINE_SPARE_B],
     line_level[vim_pkg::LINE_SPARE_C], line_level[vim_pkg::LINE_SPARE_D]} == 4'h0)
    else $error("Tied line shows a level.");
  a_sw_pend: assert property (
    SW_SET_PEND != '0 |=> (PENDING & $past(SW_SET_PEND)) == $past(SW_SET_PEND))
    else $error("Software set did not pend its lines.");

endmodule

`default_nettype wire

// ---- rtl/vim_pkg.sv ----
// Shared constants and carrier types of the vectored interrupt mapper.
package vim_pkg;

  // Line count and field widths.
  localparam int NUM_LINES  = 32;
  localparam int LINE_W     = 5;
  localparam int PRIO_W     = 2;
  localparam int EXEC_W     = 3;
  localparam int STATE_W    = 32;
  localparam int PIN_COUNT  = 11;
  localparam int NEST_DEPTH = 4;
  localparam int DEPTH_W    = 3;

  // Execution priority when no handler runs; above every level so all pass the mask.
  localparam logic [EXEC_W-1:0]  EXEC_IDLE  = 3'h4;
  localparam logic [DEPTH_W-1:0] DEPTH_NONE = 3'h0;
  localparam logic [DEPTH_W-1:0] DEPTH_ONE  = 3'h1;
  localparam logic [DEPTH_W-1:0] DEPTH_FULL = 3'h4;

  // Fixed line assignment of each source.
  localparam int LINE_RADIO_WAKE = 11;
  localparam int LINE_RTC_WAKE   = 12;
  localparam int LINE_RADIO      = 13;
  localparam int LINE_RTC        = 14;
  localparam int LINE_TWI        = 15;
  localparam int LINE_TIMER16    = 16;
  localparam int LINE_FIELD_PWR  = 17;
  localparam int LINE_TIMER32    = 18;
  localparam int LINE_BROWNOUT   = 19;
  localparam int LINE_SPI        = 20;
  localparam int LINE_TEMPERATURE_SENSOR      = 21;
  localparam int LINE_SPARE_A    = 22;
  localparam int LINE_SPARE_B    = 23;
  localparam int LINE_I2D        = 24;
  localparam int LINE_CONVERTER  = 25;
  localparam int LINE_WATCHDOG   = 26;
  localparam int LINE_FLASH      = 27;
  localparam int LINE_NVMEM      = 28;
  localparam int LINE_SPARE_C    = 29;
  localparam int LINE_SPARE_D    = 30;
  localparam int LINE_PORT0      = 31;

  // Per-line priority field array.
  typedef logic [NUM_LINES-1:0][PRIO_W-1:0] vim_prio_array_type;

  // Peripheral flag bundle, all flags from logic on this clock.
  typedef struct packed {
    logic       radio_access;
    logic       radio_command;
    logic       radio_read_ack;
    logic       rtc_event;
    logic       twi_state_change;
    logic [2:0] timer16_match;
    logic       field_power;
    logic [1:0] timer32_match;
    logic       brownout;
    logic       spi_tx_half_empty;
    logic       spi_rx_half_full;
    logic       spi_rx_timeout;
    logic       spi_rx_overrun;
    logic       temperature_sensor_done;
    logic       temperature_sensor_low;
    logic       temperature_sensor_high;
    logic       i2d_done;
    logic       i2d_low;
    logic       i2d_high;
    logic       converter_irq;
    logic       watchdog_irq;
    logic       flash_irq;
    logic       nvmem_irq;
    logic       port0_status;
  } vim_source_type;

  // Request presented to the core.
  typedef struct packed {
    logic              valid;
    logic [LINE_W-1:0] line;
    logic [PRIO_W-1:0] prio;
  } vim_request_type;

endpackage

// ---- rtl/vim_arbiter.sv ----
// Priority arbiter: picks the most urgent unmasked candidate line.
`timescale 1ns/1ps
`default_nettype none

module vim_arbiter (
  input  wire logic [vim_pkg::NUM_LINES-1:0] cand,
  input  var  vim_pkg::vim_prio_array_type   prio,
  input  wire logic [vim_pkg::EXEC_W-1:0]    exec_prio,
  output var  vim_pkg::vim_request_type      pick
);

  //////////////////////////////////////////////////////////////////////////////
  // Scan from the top line down so an equal level at a lower line replaces
  // the earlier pick; a lower level value is the more urgent one.
  always_comb begin
    logic                          any;
    logic [vim_pkg::LINE_W-1:0]    best_line;
    logic [vim_pkg::PRIO_W-1:0]    best_prio;
    any       = 1'b0;
    best_line = '0;
    best_prio = '1;
    for (int i = vim_pkg::NUM_LINES - 1; i >= 0; i--) begin
      if (cand[i] && (!any || prio[i] <= best_prio)) begin
        any       = 1'b1;
        best_line = vim_pkg::LINE_W'(i);
        best_prio = prio[i];
      end
    end
    pick.valid = any && ({1'b0, best_prio} < exec_prio);
    pick.line  = best_line;
    pick.prio  = best_prio;
  end

endmodule

`default_nettype wire

// ---- testbench/vim_core_model.sv ----
// Behavioural processor core that takes shown requests and leaves handlers.
`timescale 1ns/1ps
`default_nettype none

module vim_core_model (
  input  wire logic                     clk,
  input  var  vim_pkg::vim_request_type irq_req,
  output logic                          core_take,
  output logic                          core_return,
  output logic [vim_pkg::STATE_W-1:0]   core_state
);
  // Word handed over at the last take.
  logic [vim_pkg::STATE_W-1:0] st;

  initial begin
    core_take = 1'b0;
    core_return = 1'b0;
    st = 32'h0000_0000;
  end

  // Outside a take the inverse shows, so a design that samples late cannot pass by luck.
  assign core_state = core_take ? st : ~st;

  ////////////////////////////////////////////////////////////////////////////////
  // Waits one cycle more than the given number, then takes whatever request is shown.
  task automatic take_after(input int delay, input logic [vim_pkg::STATE_W-1:0] word);
    repeat (delay) @(negedge clk);
    @(negedge clk);
    st = word;
    core_take = irq_req.valid;
    @(negedge clk);
    core_take = 1'b0;
  endtask

  // Leaves the newest handler with a one-cycle pulse.
  task automatic return_now();
    @(negedge clk);
    core_return = 1'b1;
    @(negedge clk);
    core_return = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking testbench of the vectored interrupt mapper.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                        clk;
  logic                        rst_n;
  logic [10:0]                 pins;
  vim_pkg::vim_source_type     src;
  logic [31:0]                 en;
  vim_pkg::vim_prio_array_type prio;
  logic [31:0]                 sset;
  logic [31:0]                 sclr;
  logic                        take;
  logic                        ret;
  logic [31:0]                 cstate;
  vim_pkg::vim_request_type    req;
  logic [2:0]                  exec;
  logic [31:0]                 pend;
  logic [31:0]                 act;
  logic [31:0]                 rstate;
  logic                        rvalid;
  int                          n_fail;
  int                          checks_done;
  // Line of each source flag, most significant flag first.
  int line_of [27] = '{13, 13, 13, 14, 15, 16, 16, 16, 17, 18, 18, 19, 20, 20, 20, 20,
                       21, 21, 21, 24, 24, 24, 25, 26, 27, 28, 31};

  vim_top i_dut (.CLK(clk), .RESET_N(rst_n), .PORT0_PINS(pins), .SOURCES(src),
    .IRQ_ENABLE(en), .IRQ_PRIORITY(prio), .SW_SET_PEND(sset), .SW_CLEAR_PEND(sclr),
    .CORE_TAKE(take), .CORE_RETURN(ret), .CORE_STATE(cstate), .IRQ_REQ(req),
    .EXEC_PRIO(exec), .PENDING(pend), .ACTIVE(act), .RESTORED_STATE(rstate),
    .RESTORE_VALID(rvalid));

  vim_core_model i_core (.clk(clk), .irq_req(req), .core_take(take), .core_return(ret),
    .core_state(cstate));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rq(input logic v, input int l, input int p);
    return {24'h0, v, 5'(l), 2'(p)};
  endfunction

  // Pulses a clear of every pending bit; sources must already be quiet.
  task automatic clear_all();
    sclr = 32'hffff_ffff;
    @(negedge clk);
    sclr = 32'h0;
    chk(pend, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Each flag alone must pend its own line and nothing else; all lines disabled.
  task automatic t_sources();
    logic [26:0] b;
    logic [31:0] m;
    for (int k = 0; k < 27; k++) begin
      b = 27'h0;
      b[26 - k] = 1'b1;
      // The radio access and clock event flags also drive their wake lines.
      m = (32'h1 << line_of[k])
        | ((k == 0) ? (32'h1 << vim_pkg::LINE_RADIO_WAKE) : 32'h0)
        | ((k == 3) ? (32'h1 << vim_pkg::LINE_RTC_WAKE) : 32'h0);
      src = b;
      @(negedge clk);
      src = 27'h0;
      chk(pend & 32'h0000_ffff, m & 32'h0000_ffff);
      chk({24'h0, pend[23:16]}, {24'h0, m[23:16]});
      chk({24'h0, pend[31:24]}, {24'h0, m[31:24]});
      // Every line is disabled, so nothing may be requested; idle fields are free.
      chk({31'h0, req.valid}, 32'h0);
      clear_all();
    end
  endtask

  // Each wake pin pends its own line once it has crossed the synchroniser.
  task automatic t_pins();
    for (int p = 0; p < 11; p++) begin
      pins = 11'h1 << p;
      repeat (8) @(negedge clk);
      chk(pend, 32'h1 << p);
      pins = 11'h0;
      repeat (8) @(negedge clk);
      clear_all();
    end
  endtask

  // Software forces every line in turn; each is requested with its own level.
  task automatic t_lines();
    en = 32'hffff_ffff;
    for (int l = 0; l < 32; l++) begin
      prio[l] = 2'(l % 4);
    end
    for (int l = 0; l < 32; l++) begin
      sset = 32'h1 << l;
      @(negedge clk);
      sset = 32'h0;
      chk(pend, 32'h1 << l);
      chk({24'h0, req}, rq(1'b1, l, l % 4));
      clear_all();
    end
  endtask

  // Level beats line number; equal levels fall to the lowest line; disabled never wins.
  task automatic t_arb();
    prio[3] = 2'h2;
    prio[5] = 2'h2;
    prio[9] = 2'h1;
    sset = 32'h0000_0228;
    @(negedge clk);
    sset = 32'h0;
    chk({24'h0, req}, rq(1'b1, 9, 1));
    sclr = 32'h0000_0200;
    @(negedge clk);
    sclr = 32'h0;
    chk({24'h0, req}, rq(1'b1, 3, 2));
    en[3] = 1'b0;
    @(negedge clk);
    chk({24'h0, req}, rq(1'b1, 5, 2));
    // A set and a clear of one line in the same cycle leave it pending.
    en[3] = 1'b1;
    sset = 32'h0000_0010;
    sclr = 32'h0000_0010;
    @(negedge clk);
    sset = 32'h0;
    chk(pend, 32'h0000_0038);
    chk({24'h0, req}, rq(1'b1, 4, 0));
    clear_all();
  endtask

  // Two nested handlers, masking at the running level, state returned newest first.
  task automatic t_nest();
    prio[7] = 2'h2;
    prio[6] = 2'h2;
    prio[20] = 2'h0;
    sset = 32'h0000_0080;
    @(negedge clk);
    sset = 32'h0;
    chk({24'h0, req}, rq(1'b1, 7, 2));
    i_core.take_after(0, 32'ha5a5_0001);
    chk(act, 32'h0000_0080);
    chk(pend, 32'h0);
    chk({29'h0, exec}, 32'h2);
    sset = 32'h0010_0040;
    @(negedge clk);
    sset = 32'h0;
    chk({24'h0, req}, rq(1'b1, 20, 0));
    i_core.take_after(2, 32'h5a5a_0002);
    chk(act, 32'h0010_0080);
    chk({29'h0, exec}, 32'h0);
    chk({31'h0, req.valid}, 32'h0);
    // The newest handler leaves first and hands back the second word.
    i_core.return_now();
    chk(rstate, 32'h5a5a_0002);
    chk({31'h0, rvalid}, 32'h1);
    chk(act, 32'h0000_0080);
    chk({29'h0, exec}, 32'h2);
    chk({31'h0, req.valid}, 32'h0);
    @(negedge clk);
    chk({31'h0, rvalid}, 32'h0);
    i_core.return_now();
    chk(rstate, 32'ha5a5_0001);
    chk(act, 32'h0);
    chk({29'h0, exec}, {29'h0, vim_pkg::EXEC_IDLE});
    chk({24'h0, req}, rq(1'b1, 6, 2));
    // A return with no handler running is ignored and gives no pulse.
    i_core.return_now();
    chk({31'h0, rvalid}, 32'h0);
    clear_all();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The run needs about 340 cycles; 5000 leaves ample margin.
  initial begin
    repeat (5000) @(posedge clk);
    chk(32'h0, 32'h1);
    tally_and_finish();
  end

  initial begin
    n_fail = 0;
    checks_done = 0;
    rst_n = 1'b0;
    pins = 11'h0;
    src = 27'h0;
    en = 32'h0;
    prio = 64'h0;
    sset = 32'h0;
    sclr = 32'h0;
    repeat (8) @(negedge clk);
    // Every output sits at its reset value while reset is held.
    chk({24'h0, req}, 32'h0);
    chk(rstate, 32'h0);
    chk({31'h0, rvalid}, 32'h0);
    chk(act, 32'h0);
    chk(pend, 32'h0);
    chk({29'h0, exec}, {29'h0, vim_pkg::EXEC_IDLE});
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_sources();
    t_pins();
    t_lines();
    t_arb();
    t_nest();
    tally_and_finish();
  end
endmodule
`default_nettype wire
